// >>> dma_controller.sv
`timescale 1ns/10ps
// Overview of operation
// - count up to 65535 items, peripheral and memory widths chosen separately
// - directions: memory to memory, memory to peripheral, peripheral to memory
// - each side has its own fixed or incrementing address enable bit
// - incrementing address steps by 1, 2 or 4 bytes per that side's width
// - non-circular channel stops at count end until reprogrammed and restarted
// - count writes only take effect while the channel is off
// - circular mode reloads the programmed count and keeps serving requests
// - circular reload also returns both working addresses to their bases
// - circular operation repeats until software clears the wraparound enable
// - arbiter grants the highest of four software priority levels first
// - equal priority: lowest channel number wins
// - memory copy channels move data with no peripheral request
// - memory copy starts on channel enable and ends at zero count
// - each channel has half done, all done and fault flags
// - each flag has its own interrupt enable gating the channel interrupt
// - per-channel any-event flag sets with any of the other three
// - status holds four bits per channel: any, done, half, fault; 31:28 reserved
// - flags set only by hardware, cleared only by writing one to clear register
// - channel's any-event clear bit clears all four of its flags
// - individual clear bit clears only its flag; zeros do nothing
// - 4-bit request select field per channel picks its request line
// - channel registers repeat every 20 bytes from 0x08; select at 0xA8
// - width encoding 00 8 bits, 01 16 bits, 10 32 bits
// - count decrements per item; zero count moves nothing even if enabled
// - priority encoding 00 low, 01 medium, 10 high, 11 highest
// - direction bit 0 peripheral to memory, 1 memory to peripheral
module dma_controller #(
  parameter int NUM_CH = 7
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          wb_cyc,
  input  wire logic                          wb_stb,
  input  wire logic                          wb_we,
  input  wire logic [7:0]                    wb_adr,
  input  wire logic [3:0]                    wb_sel,
  input  wire logic [31:0]                   wb_dat_w,
  output logic      [31:0]                   wb_dat_r,
  output logic                               wb_ack,
  output logic                               m_cyc,
  output logic                               m_stb,
  output logic                               m_we,
  output logic      [31:0]                   m_adr,
  output logic      [1:0]                    m_size,
  output logic      [31:0]                   m_dat_w,
  input  wire logic [31:0]                   m_dat_r,
  input  wire logic                          m_ack,
  input  wire logic                          m_err,
  input  wire logic [NUM_CH*16-1:0]          req_lines,
  output logic      [NUM_CH-1:0]             req_done,
  output logic      [NUM_CH-1:0]             channel_irq
);

  localparam int CW = dma_defs_pkg::cfg_width;
  localparam int NW = dma_defs_pkg::count_width;
  localparam int FP = dma_defs_pkg::flags_per_channel;

  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_write
  } xfer_state_type;

  typedef struct packed {
    logic [NUM_CH-1:0][CW-1:0]  cfg;
    logic [NUM_CH-1:0][NW-1:0]  count;
    logic [NUM_CH-1:0][NW-1:0]  reload;
    logic [NUM_CH-1:0][31:0]    pbase;
    logic [NUM_CH-1:0][31:0]    mbase;
    logic [NUM_CH-1:0][31:0]    pcur;
    logic [NUM_CH-1:0][31:0]    mcur;
    logic [31:0]                flags;
    logic [31:0]                select;
    xfer_state_type             state;
    logic [2:0]                 cur;
    logic                       ack;
    logic [31:0]                rdata;
    logic                       m_cyc;
    logic                       m_we;
    logic [31:0]                m_adr;
    logic [1:0]                 m_size;
    logic [31:0]                m_dat_w;
    logic [NUM_CH-1:0]          req_done;
  } dma_state_type;

  dma_state_type s;
  dma_state_type next_s;

  logic [NUM_CH-1:0]   want;
  logic [2*NUM_CH-1:0] rank;
  logic                grant_valid;
  logic [2:0]          grant_idx;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic dma_defs_pkg::reg_kind_type decode_kind(input logic [7:0] adr);
    logic [7:0] off;
    decode_kind = dma_defs_pkg::reg_none;
    off = adr - dma_defs_pkg::channel_block_off;
    if (adr == dma_defs_pkg::event_status_off) begin
      decode_kind = dma_defs_pkg::reg_status;
    end else if (adr == dma_defs_pkg::event_flag_clear_off) begin
      decode_kind = dma_defs_pkg::reg_clear;
    end else if (adr == dma_defs_pkg::request_select_off) begin
      decode_kind = dma_defs_pkg::reg_select;
    end else if (adr >= dma_defs_pkg::channel_block_off &&
                 off < 8'(NUM_CH) * dma_defs_pkg::channel_stride) begin
      decode_kind = dma_defs_pkg::reg_kind_type'(3'(
        (off % dma_defs_pkg::channel_stride) / dma_defs_pkg::channel_slot_bytes + 8'h02));
    end
  endfunction : decode_kind

  function automatic logic [2:0] decode_chan(input logic [7:0] adr);
    decode_chan = 3'((adr - dma_defs_pkg::channel_block_off) / dma_defs_pkg::channel_stride);
  endfunction : decode_chan

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = sel[b] ? val[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : merge

  function automatic logic [31:0] step_of(input logic [1:0] w);
    case (w)
      dma_defs_pkg::width_8:  step_of = 32'h1;
      dma_defs_pkg::width_16: step_of = 32'h2;
      default:                step_of = 32'h4;
    endcase
  endfunction : step_of

  function automatic logic [31:0] width_mask(input logic [1:0] w);
    case (w)
      dma_defs_pkg::width_8:  width_mask = 32'h0000_00ff;
      dma_defs_pkg::width_16: width_mask = 32'h0000_ffff;
      default:                width_mask = 32'hffff_ffff;
    endcase
  endfunction : width_mask

  // an item address is forced onto its own width boundary
  function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] w);
    align = a & ~(step_of(w) - 32'h1);
  endfunction : align

  // ************************************************************
  // channel readiness and arbitration
  // ************************************************************
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_want
      logic [3:0] pick;
      assign pick = s.select[4*c +: 4];
      assign want[c] = s.cfg[c][dma_defs_pkg::channel_on_bit] &&
                       s.count[c] != '0 &&
                       (s.cfg[c][dma_defs_pkg::mem_copy_en_bit] ||
                        req_lines[16*c + int'(pick)]);
      assign rank[2*c +: 2] = s.cfg[c][dma_defs_pkg::channel_rank_lsb +: 2];
      assign channel_irq[c] =
        (s.flags[FP*c + dma_defs_pkg::all_done_pos] &
         s.cfg[c][dma_defs_pkg::all_done_irq_en_bit]) |
        (s.flags[FP*c + dma_defs_pkg::half_done_pos] &
         s.cfg[c][dma_defs_pkg::half_done_irq_en_bit]) |
        (s.flags[FP*c + dma_defs_pkg::xfer_fault_pos] &
         s.cfg[c][dma_defs_pkg::xfer_fault_irq_en_bit]);
    end
  endgenerate

  dma_rank_arbiter #(
    .NUM_CH (NUM_CH)
  ) u_arbiter (
    .want        (want),
    .rank        (rank),
    .grant_valid (grant_valid),
    .grant_idx   (grant_idx)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    dma_defs_pkg::reg_kind_type kind;
    logic [2:0]  ch;
    logic [2:0]  c;
    logic [CW-1:0] cfg_c;
    logic        src_mem;
    logic [1:0]  src_w;
    logic [1:0]  dst_w;
    logic [NW-1:0] left;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] wval;
    next_s   = s;
    kind     = decode_kind(wb_adr);
    ch       = decode_chan(wb_adr);
    c        = s.cur;
    cfg_c    = s.cfg[s.cur];
    src_mem  = cfg_c[dma_defs_pkg::transfer_dir_sel_bit];
    src_w    = src_mem ? cfg_c[dma_defs_pkg::memory_width_lsb +: 2]
                       : cfg_c[dma_defs_pkg::periph_width_lsb +: 2];
    dst_w    = src_mem ? cfg_c[dma_defs_pkg::periph_width_lsb +: 2]
                       : cfg_c[dma_defs_pkg::memory_width_lsb +: 2];
    left     = s.count[s.cur] - NW'(1);
    set_bits = '0;
    clr_bits = '0;
    wval     = '0;
    next_s.ack      = 1'b0;
    next_s.req_done = '0;

    // register bus, one wait state, every address answered
    if (wb_cyc && wb_stb && !s.ack) begin
      next_s.ack   = 1'b1;
      next_s.rdata = '0;
      case (kind)
        dma_defs_pkg::reg_status: next_s.rdata = {4'h0, s.flags[27:0]};
        dma_defs_pkg::reg_config: next_s.rdata = 32'(s.cfg[ch]);
        dma_defs_pkg::reg_count:  next_s.rdata = 32'(s.count[ch]);
        dma_defs_pkg::reg_pbase:  next_s.rdata = s.pbase[ch];
        dma_defs_pkg::reg_mbase:  next_s.rdata = s.mbase[ch];
        dma_defs_pkg::reg_select: next_s.rdata = s.select;
        default:                  next_s.rdata = '0;
      endcase
      if (wb_we) begin
        case (kind)
          dma_defs_pkg::reg_clear: begin
            wval = wb_dat_w & {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
            for (int k = 0; k < NUM_CH; k++) begin
              if (wval[FP*k + dma_defs_pkg::any_event_pos]) begin
                clr_bits[FP*k +: FP] = 4'hf;
              end
              clr_bits[FP*k + dma_defs_pkg::all_done_pos]   |=
                wval[FP*k + dma_defs_pkg::all_done_pos];
              clr_bits[FP*k + dma_defs_pkg::half_done_pos]  |=
                wval[FP*k + dma_defs_pkg::half_done_pos];
              clr_bits[FP*k + dma_defs_pkg::xfer_fault_pos] |=
                wval[FP*k + dma_defs_pkg::xfer_fault_pos];
            end
          end
          dma_defs_pkg::reg_config: begin
            wval = merge(32'(s.cfg[ch]), wb_dat_w, wb_sel);
            next_s.cfg[ch] = wval[CW-1:0];
            // a fresh start picks up the bases again
            if (wval[dma_defs_pkg::channel_on_bit] && !s.cfg[ch][dma_defs_pkg::channel_on_bit]) begin
              next_s.pcur[ch] = s.pbase[ch];
              next_s.mcur[ch] = s.mbase[ch];
            end
          end
          dma_defs_pkg::reg_count: begin
            if (!s.cfg[ch][dma_defs_pkg::channel_on_bit]) begin
              wval = merge(32'(s.count[ch]), wb_dat_w, wb_sel);
              next_s.count[ch]  = wval[NW-1:0];
              next_s.reload[ch] = wval[NW-1:0];
            end
          end
          dma_defs_pkg::reg_pbase: begin
            if (!s.cfg[ch][dma_defs_pkg::channel_on_bit]) begin
              next_s.pbase[ch] = merge(s.pbase[ch], wb_dat_w, wb_sel);
              next_s.pcur[ch]  = next_s.pbase[ch];
            end
          end
          dma_defs_pkg::reg_mbase: begin
            if (!s.cfg[ch][dma_defs_pkg::channel_on_bit]) begin
              next_s.mbase[ch] = merge(s.mbase[ch], wb_dat_w, wb_sel);
              next_s.mcur[ch]  = next_s.mbase[ch];
            end
          end
          dma_defs_pkg::reg_select: begin
            wval = merge(s.select, wb_dat_w, wb_sel);
            next_s.select = {4'h0, wval[27:0]};
          end
          default: begin
          end
        endcase
      end
    end

    // ************************************************************
    // transfer engine: one item is a read followed by a write
    // ************************************************************
    case (s.state)
      st_idle: begin
        if (grant_valid) begin
          next_s.cur     = grant_idx;
          next_s.state   = st_read;
          next_s.m_cyc   = 1'b1;
          next_s.m_we    = 1'b0;
          if (s.cfg[grant_idx][dma_defs_pkg::transfer_dir_sel_bit]) begin
            next_s.m_size = s.cfg[grant_idx][dma_defs_pkg::memory_width_lsb +: 2];
            next_s.m_adr  = align(s.mcur[grant_idx], next_s.m_size);
          end else begin
            next_s.m_size = s.cfg[grant_idx][dma_defs_pkg::periph_width_lsb +: 2];
            next_s.m_adr  = align(s.pcur[grant_idx], next_s.m_size);
          end
        end
      end
      st_read: begin
        if (m_err) begin
          next_s.m_cyc = 1'b0;
          next_s.state = st_idle;
          next_s.cfg[c][dma_defs_pkg::channel_on_bit] = 1'b0;
          set_bits[FP*c + dma_defs_pkg::xfer_fault_pos] = 1'b1;
        end else if (m_ack) begin
          next_s.state   = st_write;
          next_s.m_we    = 1'b1;
          next_s.m_size  = dst_w;
          next_s.m_adr   = align(src_mem ? s.pcur[c] : s.mcur[c], dst_w);
          next_s.m_dat_w = m_dat_r & width_mask(src_w) & width_mask(dst_w);
        end
      end
      st_write: begin
        if (m_err) begin
          next_s.m_cyc = 1'b0;
          next_s.m_we  = 1'b0;
          next_s.state = st_idle;
          next_s.cfg[c][dma_defs_pkg::channel_on_bit] = 1'b0;
          set_bits[FP*c + dma_defs_pkg::xfer_fault_pos] = 1'b1;
        end else if (m_ack) begin
          next_s.m_cyc       = 1'b0;
          next_s.m_we        = 1'b0;
          next_s.state       = st_idle;
          next_s.req_done[c] = 1'b1;
          next_s.count[c]    = left;
          if (cfg_c[dma_defs_pkg::periph_step_en_bit]) begin
            next_s.pcur[c] = s.pcur[c] +
              step_of(cfg_c[dma_defs_pkg::periph_width_lsb +: 2]);
          end
          if (cfg_c[dma_defs_pkg::memory_step_en_bit]) begin
            next_s.mcur[c] = s.mcur[c] +
              step_of(cfg_c[dma_defs_pkg::memory_width_lsb +: 2]);
          end
          if (left == (s.reload[c] >> 1)) begin
            set_bits[FP*c + dma_defs_pkg::half_done_pos] = 1'b1;
          end
          if (left == '0) begin
            set_bits[FP*c + dma_defs_pkg::all_done_pos] = 1'b1;
            // a zero count idles a non-wraparound channel until software reloads it; wraparound reloads count and both addresses
            if (cfg_c[dma_defs_pkg::wraparound_en_bit]) begin
              next_s.count[c] = s.reload[c];
              next_s.pcur[c]  = s.pbase[c];
              next_s.mcur[c]  = s.mbase[c];
            end
          end
        end
      end
      default: begin
        next_s.state = st_idle;
        next_s.m_cyc = 1'b0;
      end
    endcase

    // ************************************************************
    // flags: hardware set beats a same-cycle clear
    // ************************************************************
    for (int k = 0; k < NUM_CH; k++) begin
      if (|set_bits[FP*k +: FP]) begin
        set_bits[FP*k + dma_defs_pkg::any_event_pos] = 1'b1;
      end
    end
    next_s.flags = ((s.flags & ~clr_bits) | set_bits) & 32'h0fff_ffff;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s        <= '0;
      s.flags  <= dma_defs_pkg::event_status_reset;
      s.select <= dma_defs_pkg::request_sel_reset;
      s.state  <= st_idle;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack   = s.ack;
  assign wb_dat_r = s.rdata;
  assign m_cyc    = s.m_cyc;
  assign m_stb    = s.m_cyc;
  assign m_we     = s.m_we;
  assign m_adr    = s.m_adr;
  assign m_size   = s.m_size;
  assign m_dat_w  = s.m_dat_w;
  assign req_done = s.req_done;

endmodule : dma_controller

// >>> dma_defs_pkg.sv
package dma_defs_pkg;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [7:0] event_status_off     = 8'h00;
  localparam logic [7:0] event_flag_clear_off = 8'h04;
  localparam logic [7:0] channel_block_off    = 8'h08;
  localparam logic [7:0] channel_stride       = 8'h14;
  localparam logic [7:0] request_select_off   = 8'ha8;
  localparam logic [7:0] channel_slot_bytes   = 8'h04;

  localparam logic [31:0] event_status_reset  = 32'h0000_0000;
  localparam logic [31:0] request_sel_reset   = 32'h0000_0000;
  localparam logic [31:0] channel_reg_reset   = 32'h0000_0000;

  // ************************************************************
  // channel_config field positions
  // ************************************************************
  localparam int cfg_width            = 15;
  localparam int channel_on_bit       = 0;
  localparam int all_done_irq_en_bit  = 1;
  localparam int half_done_irq_en_bit = 2;
  localparam int xfer_fault_irq_en_bit = 3;
  localparam int transfer_dir_sel_bit = 4;
  localparam int wraparound_en_bit    = 5;
  localparam int periph_step_en_bit   = 6;
  localparam int memory_step_en_bit   = 7;
  localparam int periph_width_lsb     = 8;
  localparam int memory_width_lsb     = 10;
  localparam int channel_rank_lsb     = 12;
  localparam int mem_copy_en_bit      = 14;

  // ************************************************************
  // event_status field positions within one channel nibble
  // ************************************************************
  localparam int flags_per_channel    = 4;
  localparam int any_event_pos        = 0;
  localparam int all_done_pos         = 1;
  localparam int half_done_pos        = 2;
  localparam int xfer_fault_pos       = 3;

  localparam int count_width          = 16;
  localparam int request_sel_width    = 4;
  localparam int request_lines        = 16;

  // item width encodings
  localparam logic [1:0] width_8      = 2'h0;
  localparam logic [1:0] width_16     = 2'h1;
  localparam logic [1:0] width_32     = 2'h2;

  typedef enum logic [2:0] {
    reg_status, reg_clear, reg_config, reg_count, reg_pbase, reg_mbase, reg_select, reg_none
  } reg_kind_type;

endpackage : dma_defs_pkg

// >>> dma_rank_arbiter.sv
`timescale 1ns/10ps
module dma_rank_arbiter #(
  parameter int NUM_CH = 7
) (
  input  wire logic [NUM_CH-1:0]   want,
  input  wire logic [2*NUM_CH-1:0] rank,
  output logic                     grant_valid,
  output logic [2:0]               grant_idx
);

  // ************************************************************
  // two-stage choice: level first, then lowest channel number
  // ************************************************************
  always_comb begin
    grant_valid = 1'b0;
    grant_idx   = 3'h0;
    for (int lvl = 3; lvl >= 0; lvl--) begin
      for (int c = NUM_CH - 1; c >= 0; c--) begin
        if (!grant_valid && want[c] && rank[2*c +: 2] == 2'(lvl)) begin
          grant_idx = 3'(c);
        end
      end
      if (!grant_valid) begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (want[c] && rank[2*c +: 2] == 2'(lvl)) begin
            grant_valid = 1'b1;
          end
        end
      end
    end
  end

endmodule : dma_rank_arbiter

// >>> dma_controller_monitor.sv
`timescale 1ns/10ps
module dma_controller_monitor #(
  parameter int NUM_CH = 7
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              wb_cyc,
  input wire logic              wb_stb,
  input wire logic              wb_ack,
  input wire logic [31:0]       wb_dat_r,
  input wire logic              m_cyc,
  input wire logic              m_we,
  input wire logic [31:0]       m_adr,
  input wire logic [1:0]        m_size,
  input wire logic [31:0]       m_dat_w,
  input wire logic              m_ack,
  input wire logic              m_err,
  input wire logic [NUM_CH-1:0] req_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ack_answer_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("register access not acked one cycle later");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
  read_hold_a: assert property (!wb_ack ##1 !wb_ack |-> $stable(wb_dat_r))
    else $error("read data moved without an ack");
  hold_req_a: assert property (m_cyc && !m_ack && !m_err |=> m_cyc && $stable(m_adr)
    && $stable(m_we)) else $error("data move request changed before its answer");
  read_write_a: assert property (m_cyc && !m_we && m_ack |=> m_cyc && m_we)
    else $error("source read not followed by destination write");
  write_end_a: assert property (m_cyc && m_we && m_ack |=> !m_cyc && req_done != '0)
    else $error("item end without idle cycle and done pulse");
  err_abort_a: assert property (m_cyc && m_err |=> !m_cyc && req_done == '0)
    else $error("bus error did not abort the item");
  step_align_a: assert property (m_cyc && m_size != 2'h0 |-> !m_adr[0])
    else $error("wide item on odd address");
  narrow_data_a: assert property (m_cyc && m_we && m_size == 2'h0 |->
    m_dat_w[31:8] == 24'h0) else $error("byte write carries upper bits");
  cover property (m_cyc && m_err);
  cover property (m_cyc && m_we && m_ack);
  cover property (wb_ack);
endmodule : dma_controller_monitor
bind dma_controller dma_controller_monitor #(.NUM_CH(NUM_CH)) mon_u (.clk_sys(clk_sys),
  .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r),
  .m_cyc(m_cyc), .m_we(m_we), .m_adr(m_adr), .m_size(m_size), .m_dat_w(m_dat_w),
  .m_ack(m_ack), .m_err(m_err), .req_done(req_done));

// >>> dma_mem_model.sv
`timescale 1ns/10ps
module dma_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        m_cyc,
  input  wire logic        m_stb,
  input  wire logic        m_we,
  input  wire logic [31:0] m_adr,
  input  wire logic [31:0] m_dat_w,
  input  wire logic [1:0]  slow,
  output logic      [31:0] m_dat_r,
  output logic             m_ack,
  output logic             m_err,
  output logic      [31:0] w_adr,
  output logic      [31:0] w_dat
);
  logic [1:0] cnt;
  // released data toggles so a late sample is never a lucky match
  always_ff @(posedge clk_sys) begin
    m_ack <= 1'b0;
    m_err <= 1'b0;
    m_dat_r <= ~m_dat_r;
    if (rst) begin
      cnt <= 2'h0;
      m_dat_r <= 32'h0;
    end else if (m_cyc && m_stb && !m_ack && !m_err) begin
      cnt <= cnt + 2'h1;
      if (cnt == slow) begin
        cnt <= 2'h0;
        // top nibble f is unmapped: bus error
        m_err <= m_adr[31:28] == 4'hf;
        m_ack <= m_adr[31:28] != 4'hf;
        if (m_we) begin
          w_adr <= m_adr;
          w_dat <= m_dat_w;
        end else begin
          m_dat_r <= m_adr ^ 32'h5a5a_c3c3;
        end
      end
    end
  end
endmodule : dma_mem_model

// >>> test_dma_controller.sv
`timescale 1ns/10ps
module test_dma_controller;
  logic         clk_sys, rst, wb_cyc, wb_we, wb_ack, m_cyc, m_stb, m_we, m_ack, m_err;
  logic [7:0]   wb_adr;
  logic [31:0]  wb_dat_w, wb_dat_r, m_adr, m_dat_w, m_dat_r, w_adr, w_dat, q, b;
  logic [1:0]   m_size, slow;
  logic [111:0] req_lines;
  logic [6:0]   req_done, channel_irq;
  int           n_mismatch, checks_done, seed, i;
  int           ord [3] = '{2, 3, 1};
  dma_controller dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_cyc),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .m_cyc(m_cyc), .m_stb(m_stb), .m_we(m_we), .m_adr(m_adr),
    .m_size(m_size), .m_dat_w(m_dat_w), .m_dat_r(m_dat_r), .m_ack(m_ack), .m_err(m_err),
    .req_lines(req_lines), .req_done(req_done), .channel_irq(channel_irq));
  dma_mem_model mem_u (.clk_sys(clk_sys), .rst(rst), .m_cyc(m_cyc), .m_stb(m_stb),
    .m_we(m_we), .m_adr(m_adr), .m_dat_w(m_dat_w), .slow(slow), .m_dat_r(m_dat_r),
    .m_ack(m_ack), .m_err(m_err), .w_adr(w_adr), .w_dat(w_dat));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic bounded(input int k);
    if (k >= 99) chk("wait bound", 0, 1);
    if (k >= 99) close_out();
  endtask : bounded
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    wb_cyc <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    for (k = 0; k < 99 && wb_ack !== 1'b1; k++) @(posedge clk_sys);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    @(posedge clk_sys);
    bounded(k);
  endtask : bus
  // waits one item end of any channel; pulse can linger at entry, so skip an edge
  task automatic item;
    int k;
    @(posedge clk_sys);
    for (k = 0; k < 99 && req_done === 7'h0; k++) @(posedge clk_sys);
    bounded(k);
  endtask : item
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, wb_cyc, wb_we, wb_adr, wb_dat_w, req_lines, slow} = '0;
    rst = 1'b1;
    seed = 83602;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(0, 8'h00, 0);
    chk("status", 0, q);
    bus(0, 8'hfc, 0);
    chk("unmapped", 0, q);
    for (i = 0; i < 7; i++) begin
      b = $random(seed);
      bus(1, 8'h08 + 8'(20 * i), b);
      bus(0, 8'h08 + 8'(20 * i), 0);
      chk("config", b & 32'h7fff, q);
      bus(1, 8'h08 + 8'(20 * i), 0);
    end
    b = $random(seed);
    bus(1, 8'ha8, b);
    bus(0, 8'ha8, 0);
    chk("select", b & 32'h0fff_ffff, q);
    // memory copy, 32-bit source truncated to 8-bit destination
    slow <= 2'($random(seed));
    b = $random(seed) & 32'h0fff_fffc;
    bus(1, 8'h10, 32'h100);
    bus(1, 8'h14, b);
    bus(1, 8'h0c, 3);
    bus(1, 8'h08, 32'h48d3);
    for (i = 0; i < 3; i++) begin
      item();
      chk("dest addr", 32'h100 + i, w_adr);
      chk("dest data", ((b + 4 * i) ^ 32'h5a5a_c3c3) & 32'hff, w_dat);
    end
    bus(0, 8'h00, 0);
    chk("flags", 32'h7, q);
    chk("irq", 1, channel_irq[0]);
    bus(1, 8'h0c, 5);
    bus(0, 8'h0c, 0);
    chk("count", 0, q);
    chk("idle", 0, m_cyc);
    bus(1, 8'h04, 4);
    bus(0, 8'h00, 0);
    chk("half cleared", 32'h3, q);
    bus(1, 8'h04, 1);
    bus(0, 8'h00, 0);
    chk("all cleared", 0, q);
    chk("irq off", 0, channel_irq[0]);
    // three peripheral channels ask at once
    bus(1, 8'ha8, 0);
    for (i = 1; i < 4; i++) begin
      bus(1, 8'h0c + 8'(20 * i), 1);
      bus(1, 8'h14 + 8'(20 * i), 32'h40 * i);
      bus(1, 8'h08 + 8'(20 * i), i == 1 ? 32'h1001 : 32'h3001);
    end
    req_lines <= 112'h0001_0001_0001_0000;
    for (i = 0; i < 3; i++) begin
      item();
      chk("served first", 32'h40 * ord[i], w_adr);
    end
    // circular channel, 16-bit memory steps, reload after two items
    req_lines <= 112'h1 << 80;
    bus(1, 8'h0c + 8'd100, 2);
    bus(1, 8'h14 + 8'd100, 32'h300);
    bus(1, 8'h08 + 8'd100, 32'h4a1);
    for (i = 0; i < 3; i++) begin
      item();
      chk("wrap addr", 32'h300 + 2 * (i % 2), w_adr);
    end
    bus(1, 8'h08 + 8'd100, 0);
    req_lines <= '0;
    // bus error on memory-side read
    bus(1, 8'h0c + 8'd80, 2);
    bus(1, 8'h14 + 8'd80, 32'hf000_0000);
    bus(1, 8'h08 + 8'd80, 32'h4019);
    for (i = 0; i < 99 && channel_irq[4] !== 1'b1; i++) @(posedge clk_sys);
    bounded(i);
    bus(0, 8'h00, 0);
    // channels 1 to 3 and the circular one still hold their done and half flags
    chk("fault flags", 32'h0079_7770, q);
    chk("irq gated", 0, 32'(channel_irq[3:1]));
    bus(0, 8'h08 + 8'd80, 0);
    chk("fault config", 32'h4018, q);
    bus(0, 8'h0c + 8'd80, 0);
    chk("fault count", 2, q);
    close_out();
  end
endmodule : test_dma_controller
